// ==== inc/pin_select_pkg.sv ====
// constants and types for the port b pin function select block
package pin_select_pkg;
    localparam int pin_count = 8;
    localparam int sel_width = 2;
    localparam int addr_width = 4;
    localparam int data_width = 8;
    localparam logic [3:0] low_sel_offset = 4'h8;
    localparam logic [3:0] high_sel_offset = 4'h9;
    localparam logic [7:0] sel_reg_reset = 8'h00;
    localparam logic [1:0] sel_reset = 2'h0;
    localparam int retained_pin = 6;
    localparam int pins_per_reg = 4;
    typedef enum logic [1:0] {
        alternative_zero = 2'h0,
        alternative_one = 2'h1,
        alternative_two = 2'h2,
        alternative_three = 2'h3
    } alt_type;
endpackage

// ==== rtl/pin_route.sv ====
// one pin: function routing and analog isolation of the digital paths
module pin_route
    import pin_select_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] sel,
    input wire logic [3:0] analog_alt,
    input wire logic [3:0] alt_out,
    input wire logic [3:0] alt_oe,
    input wire logic [3:0] alt_pull,
    input wire logic pad_in,
    output logic pad_out_ff,
    output logic pad_oe_ff,
    output logic pad_pull_ff,
    output logic [3:0] alt_in_ff
);
    logic nxt_pad_out;
    logic nxt_pad_oe;
    logic nxt_pad_pull;
    logic [3:0] nxt_alt_in;
    logic dig;

    always_comb begin
        dig = !analog_alt[sel];
        nxt_pad_out = alt_out[sel] & dig; // RULE_01
        nxt_pad_oe = alt_oe[sel] & dig; // RULE_03
        nxt_pad_pull = alt_pull[sel] & dig; // RULE_03
        nxt_alt_in = 4'h0;
        // input buffer off for an analog choice
        if (dig) begin
            nxt_alt_in[sel] = pad_in; // RULE_01
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pad_out_ff <= 1'b0;
            pad_oe_ff <= 1'b0;
            pad_pull_ff <= 1'b0;
            alt_in_ff <= 4'h0;
        end else begin
            pad_out_ff <= nxt_pad_out;
            pad_oe_ff <= nxt_pad_oe;
            pad_pull_ff <= nxt_pad_pull;
            alt_in_ff <= nxt_alt_in;
        end
    end

    analog_iso_a: assert property (@(posedge clk) disable iff (!rstn)
        analog_alt[sel] |=> !pad_oe_ff && !pad_pull_ff && alt_in_ff == 4'h0)
        else $error("digital path active on analog selection"); // RULE_03
endmodule

// ==== rtl/port_b_pin_function_select.sv ====
// port b pin function select registers and per-pin routing
// Summary of operation
// (RULE_01) selector code picks one of four alternatives
// (RULE_02) all selectors zero after reset; pin 6 is kept through system reset and cleared only by power-on reset
// (RULE_03) analog choice disables pull, driver, input
// (RULE_04) analog taps bypass the selector always
// (RULE_05) low register 8h holds pins 3..0
// (RULE_06) high register 9h holds pins 7..4
// (RULE_07) pin 6 cleared by power-on reset only
// (RULE_08) fields read/write, routing follows next cycle
//
// Implementation choice: the plain strobed port.
module port_b_pin_function_select
    import pin_select_pkg::*;
#(
    parameter int pins = pin_count,
    parameter logic [3:0] analog_map [pin_count] = '{default: 4'h0}
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic por_rstn,
    input wire logic [addr_width-1:0] addr,
    input wire logic [data_width-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [data_width-1:0] rdata_ff,
    input wire logic [pins-1:0] pad_in,
    output logic [pins-1:0] pad_out_ff,
    output logic [pins-1:0] pad_oe_ff,
    output logic [pins-1:0] pad_pull_ff,
    output logic [pins-1:0] analog_tap_ff,
    input wire logic [4*pins-1:0] alt_out,
    input wire logic [4*pins-1:0] alt_oe,
    input wire logic [4*pins-1:0] alt_pull,
    output logic [4*pins-1:0] alt_in_ff,
    output logic [2*pins-1:0] sel_ff
);
    logic [2*pins-1:0] nxt_sel;
    logic [7:0] nxt_rdata;
    logic [1:0] keep6_ff;
    logic [1:0] nxt_keep6;
    logic [2*pins-1:0] sel_cur;
    logic [2*pins-1:0] sel_reg_ff;

    // pin 6 lives in its own flop so that system reset cannot reach it;
    // the pin 6 bits of sel_reg_ff are never looked at
    always_comb begin
        sel_cur = sel_reg_ff;
        sel_cur[2*retained_pin +: 2] = keep6_ff; // RULE_07
    end

    assign sel_ff = sel_cur;

    always_comb begin
        nxt_sel = sel_cur;
        if (wr && addr == low_sel_offset) begin
            nxt_sel[7:0] = wdata; // RULE_05
        end
        if (wr && addr == high_sel_offset) begin
            nxt_sel[15:8] = wdata; // RULE_06
        end
        nxt_keep6 = nxt_sel[2*retained_pin +: 2];
        nxt_rdata = 8'h00;
        if (rd && addr == low_sel_offset) begin
            nxt_rdata = sel_cur[7:0]; // RULE_08
        end else if (rd && addr == high_sel_offset) begin
            nxt_rdata = sel_cur[15:8]; // RULE_08
        end
    end

    // system reset leaves pin 6 alone; only power-on clears it
    always_ff @(posedge clk or negedge por_rstn) begin
        if (!por_rstn) begin
            keep6_ff <= sel_reset; // RULE_07
        end else begin
            keep6_ff <= nxt_keep6;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_reg_ff <= {2*pins{1'b0}}; // RULE_02
            rdata_ff <= sel_reg_reset;
            analog_tap_ff <= {pins{1'b0}};
        end else begin
            sel_reg_ff <= nxt_sel; // RULE_08
            rdata_ff <= nxt_rdata;
            analog_tap_ff <= pad_in; // RULE_04
        end
    end

    genvar i;
    generate
        for (i = 0; i < pins; i++) begin : g_pin
            pin_route u_route (
                .clk(clk),
                .rstn(rstn),
                .sel(sel_cur[2*i +: 2]), // RULE_01
                .analog_alt(analog_map[i]),
                .alt_out(alt_out[4*i +: 4]),
                .alt_oe(alt_oe[4*i +: 4]),
                .alt_pull(alt_pull[4*i +: 4]),
                .pad_in(pad_in[i]),
                .pad_out_ff(pad_out_ff[i]),
                .pad_oe_ff(pad_oe_ff[i]),
                .pad_pull_ff(pad_pull_ff[i]),
                .alt_in_ff(alt_in_ff[4*i +: 4])
            );

            pin_out_a: assert property ( // RULE_01
                @(posedge clk) disable iff (!rstn)
                !analog_map[i][sel_cur[2*i +: 2]]
                |=> pad_out_ff[i] == $past(alt_out[4*i + sel_cur[2*i +: 2]]))
                else $error("pin output not routed");
            pin_oe_a: assert property ( // RULE_01
                @(posedge clk) disable iff (!rstn)
                !analog_map[i][sel_cur[2*i +: 2]]
                |=> pad_oe_ff[i] == $past(alt_oe[4*i + sel_cur[2*i +: 2]]))
                else $error("pin enable not routed");
            pin_pull_a: assert property ( // RULE_01
                @(posedge clk) disable iff (!rstn)
                !analog_map[i][sel_cur[2*i +: 2]]
                |=> pad_pull_ff[i] == $past(alt_pull[4*i + sel_cur[2*i +: 2]]))
                else $error("pin pull not routed");
            pin_off_a: assert property ( // RULE_03
                @(posedge clk) disable iff (!rstn)
                analog_map[i][sel_cur[2*i +: 2]]
                |=> !pad_out_ff[i] && !pad_oe_ff[i] && !pad_pull_ff[i]
                && alt_in_ff[4*i +: 4] == 4'h0)
                else $error("digital path left on analog pin");
            pin_in_a: assert property ( // RULE_01
                @(posedge clk) disable iff (!rstn)
                !analog_map[i][sel_cur[2*i +: 2]]
                |=> alt_in_ff[4*i +: 4]
                == $past(4'(pad_in[i]) << sel_cur[2*i +: 2]))
                else $error("pin input not routed");
            pin_tap_a: assert property ( // RULE_04
                @(posedge clk) disable iff (!rstn)
                1'b1 |=> analog_tap_ff[i] == $past(pad_in[i]))
                else $error("analog tap lost on pin");
        end
    endgenerate

    low_write_a: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == low_sel_offset |=> sel_ff[7:0] == $past(wdata))
        else $error("low register write lost"); // RULE_05
    high_write_a: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == high_sel_offset |=> keep6_ff == $past(wdata[5:4]))
        else $error("pin 6 selector write lost"); // RULE_06
    read_back_a: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == high_sel_offset |=> rdata_ff[5:4] == $past(keep6_ff))
        else $error("read data mismatch"); // RULE_08
    unmapped_read_a: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr != low_sel_offset && addr != high_sel_offset
        |=> rdata_ff == 8'h00)
        else $error("unmapped read not zero"); // RULE_08
    tap_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> analog_tap_ff == $past(pad_in))
        else $error("analog tap not following pad"); // RULE_04
    route_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        sel_cur[1:0] == 2'h0 && !analog_map[0][0]
        |=> pad_oe_ff[0] == $past(alt_oe[0]))
        else $error("pin 0 alternative 0 not routed"); // RULE_01
    keep_hold_a: assert property (@(posedge clk) disable iff (!por_rstn)
        !(wr && addr == high_sel_offset) |=> $stable(keep6_ff))
        else $error("pin 6 selector changed without write"); // RULE_07
    // pin 6 is masked: system reset must leave it alone
    reset_zero_a: assert property (@(posedge clk)
        !rstn |-> (sel_ff & 16'hcfff) == 16'h0000)
        else $error("selectors not zero in reset"); // RULE_02

    high_rest_write_a: assert property ( // RULE_06
        @(posedge clk) disable iff (!rstn)
        wr && addr == high_sel_offset
        |=> {sel_ff[15:14], sel_ff[11:8]} == $past({wdata[7:6], wdata[3:0]}))
        else $error("high register write lost");
    low_read_a: assert property ( // RULE_05
        @(posedge clk) disable iff (!rstn)
        rd && addr == low_sel_offset |=> rdata_ff == $past(sel_ff[7:0]))
        else $error("low register read wrong");
    high_read_a: assert property ( // RULE_06
        @(posedge clk) disable iff (!rstn)
        rd && addr == high_sel_offset |=> rdata_ff == $past(sel_ff[15:8]))
        else $error("high register read wrong");
    rdata_idle_a: assert property ( // RULE_08
        @(posedge clk) disable iff (!rstn)
        !rd |=> rdata_ff == 8'h00)
        else $error("read data not zero when idle");
    por_clear_a: assert property ( // RULE_07
        @(posedge clk)
        !por_rstn |-> keep6_ff == 2'h0)
        else $error("pin 6 selector not cleared");
    unmapped_write_a: assert property ( // RULE_08
        @(posedge clk) disable iff (!rstn || !por_rstn)
        wr && addr != low_sel_offset && addr != high_sel_offset
        |=> sel_ff == $past(sel_ff))
        else $error("unmapped write changed selectors");
    low_hold_a: assert property ( // RULE_05
        @(posedge clk) disable iff (!rstn)
        !(wr && addr == low_sel_offset) |=> $stable(sel_ff[7:0]))
        else $error("low selectors changed without write");
    high_hold_a: assert property ( // RULE_06
        @(posedge clk) disable iff (!rstn)
        !(wr && addr == high_sel_offset)
        |=> $stable({sel_ff[15:14], sel_ff[11:8]}))
        else $error("high selectors changed without write");
endmodule

// ==== tb/port_b_pin_function_select_test.sv ====
// self-checking bench for the port b pin function select block
module port_b_pin_function_select_test;
import pin_select_pkg::*;
timeunit 1ns;
timeprecision 1ps;
logic clk = 0, rstn = 1, por_rstn = 1, wr = 0, rd = 0;
logic [3:0] addr = 4'h0;
logic [7:0] wdata = 8'h00, rdata, pad_out, pad_oe, pad_pull, tap;
logic [7:0] pad_in = 8'h5a;
logic [31:0] ao = 32'ha5c36e19, aoe = 32'h3c5a96f0, ap = 32'h0ff0f00f, ai;
logic [15:0] sel;
int err_count = 0, n_compared = 0, cycles = 0;
// pin 3 alternative 3 is analog
localparam logic [3:0] amap [8] = '{3: 4'h8, default: 4'h0};
port_b_pin_function_select #(.analog_map(amap)) u_port_b_pin_function_select (
    .clk(clk), .rstn(rstn), .por_rstn(por_rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata), .pad_in(pad_in),
    .pad_out_ff(pad_out), .pad_oe_ff(pad_oe), .pad_pull_ff(pad_pull),
    .analog_tap_ff(tap), .alt_out(ao), .alt_oe(aoe), .alt_pull(ap),
    .alt_in_ff(ai), .sel_ff(sel));
initial begin
    forever #2.5 clk = ~clk;
end
task final_report();
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
always @(posedge clk) begin
    cycles <= cycles + 1;
    // generous ceiling; the whole run needs about 33 cycles
    if (cycles == 2000) begin
        err_count = err_count + 1;
        final_report();
    end
end
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
endtask
task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
endtask
task t_reset();
    rd_chk(4'h8, 8'h00);
    rd_chk(4'h9, 8'h00);
    chk(sel, 16'h0000);
endtask
task t_regs();
    wr_reg(4'h8, 8'he4);
    wr_reg(4'h9, 8'h1b);
    wr_reg(4'h3, 8'hff);
    rd_chk(4'h8, 8'he4);
    rd_chk(4'h9, 8'h1b);
    rd_chk(4'h3, 8'h00);
endtask
task t_route();
    logic [1:0] s;
    logic an;
    logic [7:0] eo, eoe, ep;
    logic [31:0] eai;
    for (int i = 0; i < 8; i++) begin
        s = 2'((i < 4) ? 8'he4 >> (2 * i) : 8'h1b >> (2 * (i - 4)));
        an = amap[i][s];
        eo[i] = !an && ao[4 * i + s];
        eoe[i] = !an && aoe[4 * i + s];
        ep[i] = !an && ap[4 * i + s];
        eai[4 * i +: 4] = an ? 4'h0 : 4'(pad_in[i]) << s;
    end
    #1;
    chk(pad_out, eo);
    chk(pad_oe, eoe);
    chk(pad_pull, ep);
    chk(ai, eai);
    chk(tap, pad_in);
endtask
task t_retain();
    wr_reg(4'h9, 8'hff);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd_chk(4'h9, 8'h30);
    chk(sel, 32'h3000);
    @(posedge clk);
    por_rstn <= 1'b0;
    @(posedge clk);
    por_rstn <= 1'b1;
    rd_chk(4'h9, 8'h00);
endtask
initial begin
    // drive low at time zero so the asynchronous resets see an edge
    rstn <= 1'b0;
    por_rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    t_reset();
    t_regs();
    repeat (2) @(posedge clk);
    t_route();
    t_retain();
    final_report();
end
endmodule
